// [shared/eehc_regs.svh]
// timing counts, field positions and fixed codes of the two-wire eeprom host
`ifndef EEHC_REGS_SVH
`define EEHC_REGS_SVH
`define EEHC_CLK_NS    5
`define EEHC_SCL_NS    2500
// one quarter of an scl period in clk cycles, rounded up, minus one
`define EEHC_QTR_LAST  8'((`EEHC_SCL_NS / 4 + `EEHC_CLK_NS - 1) / `EEHC_CLK_NS - 1)
// device type code: arbitrary value, must match the target part's code
`define EEHC_DEV_TYPE  4'h5
`define EEHC_HI_PAD    4'h0
`define EEHC_BLK_MSB   11
`define EEHC_BLK_LSB   8
`define EEHC_COL_MSB   4
`define EEHC_ROW_BYTES 6'h20
`define EEHC_LAST_BIT  3'h7
`define EEHC_POLL_MAX  8'hff
`define EEHC_RW_WRITE  1'h0
`define EEHC_RW_READ   1'h1
`define EEHC_ACK       1'h0
`define EEHC_NACK      1'h1
`define EEHC_ONE_LEFT  13'h0001
`endif

// [shared/eehc_pkg.sv]
// types shared by the two-wire eeprom host modules
package eehc_pkg;
  typedef enum logic [1:0] {
    EEHC_OP_START = 2'h0,
    EEHC_OP_WR    = 2'h1,
    EEHC_OP_RD    = 2'h3,
    EEHC_OP_STOP  = 2'h2
  } eehc_bit_op_e;
  typedef enum logic [1:0] {
    EEHC_CMD_WRITE    = 2'h0,
    EEHC_CMD_READ_CUR = 2'h1,
    EEHC_CMD_READ_RND = 2'h2
  } eehc_cmd_e;
  typedef enum logic [2:0] {
    EEHC_SEL_W   = 3'h0,
    EEHC_ADDR_HI = 3'h1,
    EEHC_ADDR_LO = 3'h3,
    EEHC_DATA_W  = 3'h2,
    EEHC_SEL_R   = 3'h6
  } eehc_step_e;
  typedef enum logic [3:0] {
    EEHC_IDLE   = 4'h0,
    EEHC_START  = 4'h1,
    EEHC_TXBYTE = 4'h3,
    EEHC_TXACK  = 4'h2,
    EEHC_WAITD  = 4'h6,
    EEHC_RXBYTE = 4'h7,
    EEHC_RXACK  = 4'h5,
    EEHC_STOP   = 4'h4
  } eehc_state_e;
endpackage

// [shared/eehc_bit_if.sv]
// bit-level request and answer between the byte sequencer and the bit engine
`timescale 1ns/10ps
interface eehc_bit_if;
  logic                   req;
  eehc_pkg::eehc_bit_op_e op;
  logic                   wbit;
  logic                   ready;
  logic                   done;
  logic                   rbit;
  logic                   sda_s;
  modport ctl    (output req, op, wbit, sda_s, input ready, done, rbit);
  modport engine (input req, op, wbit, sda_s, output ready, done, rbit);
endinterface

// [verilog/eehc_sync.sv]
// two-flop synchroniser for the sda pin
`timescale 1ns/10ps
module eehc_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  // bus idles high, so both stages reset high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// [verilog/eehc_bit_engine.sv]
// scl divider and single-bit engine: start, stop, write bit, read bit
`timescale 1ns/10ps
`include "eehc_regs.svh"
module eehc_bit_engine (
  input  wire logic  clk,
  input  wire logic  rst_b,
  eehc_bit_if.engine bus,
  output logic       scl_o,
  output logic       sda_oe
);
  localparam int BIT_MIN = 400;
  localparam int BIT_MAX = 600;

  logic                   busy_q;
  logic                   done_q;
  logic                   rbit_q;
  logic [1:0]             phase_q;
  logic [7:0]             cnt_q;
  eehc_pkg::eehc_bit_op_e op_q;
  logic                   take;
  logic                   qend;
  logic [9:0]             slot_q;

  assign take      = bus.req && !busy_q;
  assign qend      = busy_q && (cnt_q == `EEHC_QTR_LAST);
  assign bus.ready = !busy_q;
  assign bus.done  = done_q;
  assign bus.rbit  = rbit_q;

  // ----------------------------------------------------------------
  // quarter-period divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q  <= 1'b0;
      phase_q <= 2'h0;
      cnt_q   <= 8'h00;
      op_q    <= eehc_pkg::EEHC_OP_STOP;
      done_q  <= 1'b0;
    end else begin
      done_q <= qend && (phase_q == 2'h3);
      if (take) begin
        busy_q  <= 1'b1;
        phase_q <= 2'h0;
        cnt_q   <= 8'h00;
        op_q    <= bus.op;
      end else if (qend) begin
        cnt_q   <= 8'h00;
        phase_q <= phase_q + 2'h1;
        if (phase_q == 2'h3) begin
          busy_q <= 1'b0;
        end
      end else if (busy_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin levels; sda moves only with scl low except in start and stop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_o  <= 1'b1;
      sda_oe <= 1'b0;
    end else if (take) begin
      scl_o <= 1'b0;
      case (bus.op)
        eehc_pkg::EEHC_OP_STOP: sda_oe <= 1'b1;
        eehc_pkg::EEHC_OP_WR:   sda_oe <= !bus.wbit;
        default:                sda_oe <= 1'b0;
      endcase
    end else if (qend) begin
      case (phase_q)
        2'h0: scl_o <= 1'b1;
        2'h1: begin
          if (op_q == eehc_pkg::EEHC_OP_START) begin
            sda_oe <= 1'b1;
          end else if (op_q == eehc_pkg::EEHC_OP_STOP) begin
            sda_oe <= 1'b0;
          end
        end
        2'h2: scl_o <= (op_q == eehc_pkg::EEHC_OP_STOP);
        default: ;
      endcase
    end
  end

  // sample at the end of the high half, in the cycle scl is driven low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rbit_q <= 1'b1;
    end else if (qend && phase_q == 2'h2) begin
      rbit_q <= bus.sda_s;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // cycles since the last bit was taken; saturates so it never wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_q <= 10'h000;
    end else if (take) begin
      slot_q <= 10'h000;
    end else if (slot_q != 10'h3ff) begin
      slot_q <= slot_q + 10'h001;
    end
  end

  sequence s_take;
    bus.req && !busy_q;
  endsequence

  property p_bit_time;
    @(posedge clk) disable iff (!rst_b)
      s_take |-> ##[BIT_MIN:BIT_MAX] done_q;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("bit slot length wrong");

  property p_bit_early;
    @(posedge clk) disable iff (!rst_b)
      done_q |-> slot_q >= BIT_MIN && slot_q <= BIT_MAX;
  endproperty
  a_bit_early: assert property (p_bit_early) else $error("bit slot ended early");

  property p_sda_hold;
    @(posedge clk) disable iff (!rst_b)
      busy_q && scl_o && $past(scl_o) && op_q inside {eehc_pkg::EEHC_OP_WR, eehc_pkg::EEHC_OP_RD}
      |-> $stable(sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved while scl high");

  property p_rd_release;
    @(posedge clk) disable iff (!rst_b)
      busy_q && op_q == eehc_pkg::EEHC_OP_RD |-> !sda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("sda driven during read bit");

  property p_start_cond;
    @(posedge clk) disable iff (!rst_b)
      busy_q && op_q == eehc_pkg::EEHC_OP_START && $rose(sda_oe) |-> scl_o;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("start not with scl high");
endmodule

// [verilog/eehc_master.sv]
// two-wire eeprom host: byte sequencer for write, read and ack polling
`timescale 1ns/10ps
`include "eehc_regs.svh"
// Behaviour
// - transmitter releases sda; receiver acks ninth
// - sda stable while scl high
// - start, select byte, direction bit, stop
// - two address bytes, high byte first
// - high byte bits above b11 sent zero
// - byte write: one byte then stop
// - never send past end of row
// - poll with start and select until ack; code stops after 255 retries and sets fail
// - current read: one byte, no ack, stop
// - random read: dummy write, restart, read
// - sequential read: ack each, nack last
// - both random-read select codes share device and strap bits, differ in direction bit
module eehc_master (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  eehc_pkg::eehc_cmd_e      cmd_op,
  input  wire logic [11:0]         cmd_addr,
  input  wire logic [12:0]         cmd_len,
  input  wire logic [2:0]          strap_sel,
  input  wire logic                protect_en,
  input  wire logic                wr_valid,
  output logic                     wr_ready,
  input  wire logic [7:0]          wr_data,
  output logic                     rd_valid,
  output logic [7:0]               rd_data,
  output logic                     done,
  output logic                     fail,
  output logic                     busy,
  output logic                     scl_o,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  output logic                     write_protect_input,
  output logic [2:0]               select_strap_pins
);
  localparam int POLL_GAP = 600;

  eehc_bit_if bif ();

  eehc_pkg::eehc_state_e state_q;
  eehc_pkg::eehc_step_e  step_q;
  eehc_pkg::eehc_cmd_e   op_q;
  logic [11:0]           addr_q;
  logic [12:0]           len_q;
  logic [7:0]            shift_q;
  logic [2:0]            bit_cnt_q;
  logic [7:0]            poll_q;
  logic                  retry_q;
  logic                  pend_q;
  logic                  last_ack_q;
  logic                  ld_cmd;
  logic                  go;
  logic                  ack;
  logic                  one_left;
  logic [5:0]            row_left;
  logic [12:0]           len_in;
  logic [12:0]           eff_len;

  // ----------------------------------------------------------------
  // byte to send for each addressing step
  // ----------------------------------------------------------------
  function automatic logic [7:0] step_byte(
    input eehc_pkg::eehc_step_e s,
    input logic [2:0]           strap,
    input logic [11:0]          a
  );
    logic [7:0] b;
    b = {`EEHC_DEV_TYPE, strap, `EEHC_RW_WRITE};
    case (s)
      eehc_pkg::EEHC_SEL_R:   b = {`EEHC_DEV_TYPE, strap, `EEHC_RW_READ};
      eehc_pkg::EEHC_ADDR_HI: b = {`EEHC_HI_PAD, a[`EEHC_BLK_MSB:`EEHC_BLK_LSB]};
      eehc_pkg::EEHC_ADDR_LO: b = a[`EEHC_BLK_LSB-1:0];
      default:                b = {`EEHC_DEV_TYPE, strap, `EEHC_RW_WRITE};
    endcase
    return b;
  endfunction

  eehc_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (sda_i),
    .q     (bif.sda_s)
  );

  eehc_bit_engine u_eng (
    .clk    (clk),
    .rst_b  (rst_b),
    .bus    (bif.engine),
    .scl_o  (scl_o),
    .sda_oe (sda_oe)
  );

  assign sda_o     = 1'b0;
  assign cmd_ready = (state_q == eehc_pkg::EEHC_IDLE);
  assign wr_ready  = (state_q == eehc_pkg::EEHC_WAITD);
  assign busy      = (state_q != eehc_pkg::EEHC_IDLE);
  assign ld_cmd    = cmd_valid && cmd_ready;
  assign go        = bif.done;
  assign ack       = (bif.rbit == `EEHC_ACK);
  assign one_left  = (len_q == `EEHC_ONE_LEFT);

  // ----------------------------------------------------------------
  // length: a page write is cut at the end of its row
  // ----------------------------------------------------------------
  always_comb begin
    row_left = `EEHC_ROW_BYTES - {1'b0, cmd_addr[`EEHC_COL_MSB:0]};
    len_in   = (cmd_len == '0) ? `EEHC_ONE_LEFT : cmd_len;
    eff_len  = len_in;
    if (cmd_op == eehc_pkg::EEHC_CMD_WRITE && len_in > {7'h00, row_left}) begin
      eff_len = {7'h00, row_left};
    end
  end

  // ----------------------------------------------------------------
  // bit requests
  // ----------------------------------------------------------------
  always_comb begin
    bif.op   = eehc_pkg::EEHC_OP_RD;
    bif.wbit = 1'b1;
    bif.req  = 1'b0;
    case (state_q)
      eehc_pkg::EEHC_START: begin
        bif.op  = eehc_pkg::EEHC_OP_START;
        bif.req = !pend_q;
      end
      eehc_pkg::EEHC_TXBYTE: begin
        bif.op   = eehc_pkg::EEHC_OP_WR;
        bif.wbit = shift_q[7];
        bif.req  = !pend_q;
      end
      eehc_pkg::EEHC_TXACK: begin
        bif.req = !pend_q;
      end
      eehc_pkg::EEHC_RXBYTE: begin
        bif.req = !pend_q;
      end
      eehc_pkg::EEHC_RXACK: begin
        bif.op   = eehc_pkg::EEHC_OP_WR;
        bif.wbit = one_left ? `EEHC_NACK : `EEHC_ACK;
        bif.req  = !pend_q;
      end
      eehc_pkg::EEHC_STOP: begin
        bif.op  = eehc_pkg::EEHC_OP_STOP;
        bif.req = !pend_q;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q     <= 1'b0;
      last_ack_q <= 1'b0;
    end else if (bif.req && bif.ready) begin
      pend_q <= 1'b1;
    end else if (go) begin
      pend_q     <= 1'b0;
      last_ack_q <= (state_q == eehc_pkg::EEHC_TXACK) || (state_q == eehc_pkg::EEHC_RXACK);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= eehc_pkg::EEHC_IDLE;
      step_q  <= eehc_pkg::EEHC_SEL_W;
      op_q    <= eehc_pkg::EEHC_CMD_WRITE;
      poll_q  <= 8'h00;
      retry_q <= 1'b0;
      fail    <= 1'b0;
    end else if (ld_cmd) begin
      op_q    <= cmd_op;
      step_q  <= (cmd_op == eehc_pkg::EEHC_CMD_READ_CUR) ?
                 eehc_pkg::EEHC_SEL_R : eehc_pkg::EEHC_SEL_W;
      state_q <= eehc_pkg::EEHC_START;
      poll_q  <= 8'h00;
      retry_q <= 1'b0;
      fail    <= 1'b0;
    end else if (go) begin
      case (state_q)
        eehc_pkg::EEHC_START: state_q <= eehc_pkg::EEHC_TXBYTE;
        eehc_pkg::EEHC_TXBYTE: begin
          if (bit_cnt_q == `EEHC_LAST_BIT) begin
            state_q <= eehc_pkg::EEHC_TXACK;
          end
        end
        eehc_pkg::EEHC_TXACK: begin
          if (!ack) begin
            state_q <= eehc_pkg::EEHC_STOP;
            if ((step_q == eehc_pkg::EEHC_SEL_W || step_q == eehc_pkg::EEHC_SEL_R)
                && poll_q != `EEHC_POLL_MAX) begin
              // busy programming: stop and try the select again
              retry_q <= 1'b1;
              poll_q  <= poll_q + 8'h01;
            end else begin
              fail <= 1'b1;
            end
          end else begin
            case (step_q)
              eehc_pkg::EEHC_SEL_W: begin
                step_q  <= eehc_pkg::EEHC_ADDR_HI;
                state_q <= eehc_pkg::EEHC_TXBYTE;
              end
              eehc_pkg::EEHC_ADDR_HI: begin
                step_q  <= eehc_pkg::EEHC_ADDR_LO;
                state_q <= eehc_pkg::EEHC_TXBYTE;
              end
              eehc_pkg::EEHC_ADDR_LO: begin
                if (op_q == eehc_pkg::EEHC_CMD_WRITE) begin
                  step_q  <= eehc_pkg::EEHC_DATA_W;
                  state_q <= eehc_pkg::EEHC_WAITD;
                end else begin
                  step_q  <= eehc_pkg::EEHC_SEL_R;
                  state_q <= eehc_pkg::EEHC_START;
                end
              end
              eehc_pkg::EEHC_DATA_W: begin
                state_q <= one_left ? eehc_pkg::EEHC_STOP : eehc_pkg::EEHC_WAITD;
              end
              eehc_pkg::EEHC_SEL_R: state_q <= eehc_pkg::EEHC_RXBYTE;
              default: state_q <= eehc_pkg::EEHC_STOP;
            endcase
          end
        end
        eehc_pkg::EEHC_RXBYTE: begin
          if (bit_cnt_q == `EEHC_LAST_BIT) begin
            state_q <= eehc_pkg::EEHC_RXACK;
          end
        end
        eehc_pkg::EEHC_RXACK: begin
          state_q <= one_left ? eehc_pkg::EEHC_STOP : eehc_pkg::EEHC_RXBYTE;
        end
        eehc_pkg::EEHC_STOP: begin
          state_q <= retry_q ? eehc_pkg::EEHC_START : eehc_pkg::EEHC_IDLE;
          retry_q <= 1'b0;
        end
        default: state_q <= eehc_pkg::EEHC_IDLE;
      endcase
    end else if (state_q == eehc_pkg::EEHC_WAITD && wr_valid) begin
      state_q <= eehc_pkg::EEHC_TXBYTE;
    end
  end

  // ----------------------------------------------------------------
  // shift register, counters and address mirror
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
      len_q     <= 13'h0000;
      addr_q    <= 12'h000;
    end else if (ld_cmd) begin
      bit_cnt_q <= 3'h0;
      len_q     <= eff_len;
      addr_q    <= cmd_addr;
    end else if (go) begin
      case (state_q)
        eehc_pkg::EEHC_START: shift_q <= step_byte(step_q, select_strap_pins, addr_q);
        eehc_pkg::EEHC_TXBYTE: begin
          shift_q   <= {shift_q[6:0], 1'b1};
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        eehc_pkg::EEHC_TXACK: begin
          if (step_q == eehc_pkg::EEHC_SEL_W) begin
            shift_q <= step_byte(eehc_pkg::EEHC_ADDR_HI, select_strap_pins, addr_q);
          end else if (step_q == eehc_pkg::EEHC_ADDR_HI) begin
            shift_q <= step_byte(eehc_pkg::EEHC_ADDR_LO, select_strap_pins, addr_q);
          end else if (step_q == eehc_pkg::EEHC_DATA_W) begin
            len_q <= len_q - 13'h0001;
            addr_q[`EEHC_COL_MSB:0] <= addr_q[`EEHC_COL_MSB:0] + 5'h01;
          end
        end
        eehc_pkg::EEHC_RXBYTE: begin
          shift_q   <= {shift_q[6:0], bif.rbit};
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        eehc_pkg::EEHC_RXACK: begin
          len_q  <= len_q - 13'h0001;
          addr_q <= addr_q + 12'h001;
        end
        default: ;
      endcase
    end else if (state_q == eehc_pkg::EEHC_WAITD && wr_valid) begin
      shift_q <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // user outputs and device side pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      done     <= 1'b0;
    end else begin
      rd_valid <= go && state_q == eehc_pkg::EEHC_RXBYTE && bit_cnt_q == `EEHC_LAST_BIT;
      if (go && state_q == eehc_pkg::EEHC_RXBYTE && bit_cnt_q == `EEHC_LAST_BIT) begin
        rd_data <= {shift_q[6:0], bif.rbit};
      end
      done <= go && state_q == eehc_pkg::EEHC_STOP && !retry_q;
    end
  end

  // held for the whole command so protection covers start through address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_protect_input <= 1'b0;
      select_strap_pins   <= 3'h0;
    end else if (ld_cmd) begin
      write_protect_input <= protect_en;
      select_strap_pins   <= strap_sel;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_sel_nack;
    go && state_q == eehc_pkg::EEHC_TXACK && !ack && poll_q != `EEHC_POLL_MAX
      && (step_q == eehc_pkg::EEHC_SEL_W || step_q == eehc_pkg::EEHC_SEL_R);
  endsequence

  sequence s_restart;
    state_q == eehc_pkg::EEHC_STOP ##[1:POLL_GAP] state_q == eehc_pkg::EEHC_START;
  endsequence

  property p_poll;
    @(posedge clk) disable iff (!rst_b) s_sel_nack |=> s_restart;
  endproperty
  a_poll: assert property (p_poll) else $error("no retry after select nack");

  property p_stop_slot;
    @(posedge clk) disable iff (!rst_b)
      bif.req && bif.ready && state_q == eehc_pkg::EEHC_STOP |-> last_ack_q;
  endproperty
  a_stop_slot: assert property (p_stop_slot) else $error("stop not after ack bit");

  property p_hi_zero;
    @(posedge clk) disable iff (!rst_b)
      state_q == eehc_pkg::EEHC_TXBYTE && step_q == eehc_pkg::EEHC_ADDR_HI && bit_cnt_q == 3'h0
      |-> shift_q[7:4] == `EEHC_HI_PAD && shift_q[3:0] == addr_q[`EEHC_BLK_MSB:`EEHC_BLK_LSB];
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high address byte wrong");

  property p_sel_code;
    @(posedge clk) disable iff (!rst_b)
      state_q == eehc_pkg::EEHC_TXBYTE && bit_cnt_q == 3'h0
      && (step_q == eehc_pkg::EEHC_SEL_W || step_q == eehc_pkg::EEHC_SEL_R)
      |-> shift_q == {`EEHC_DEV_TYPE, select_strap_pins, step_q == eehc_pkg::EEHC_SEL_R};
  endproperty
  a_sel_code: assert property (p_sel_code) else $error("select byte wrong");

  property p_rx_ack;
    @(posedge clk) disable iff (!rst_b)
      bif.req && state_q == eehc_pkg::EEHC_RXACK |-> bif.wbit == one_left;
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("read ack level wrong");

  property p_row;
    @(posedge clk) disable iff (!rst_b)
      op_q == eehc_pkg::EEHC_CMD_WRITE && state_q != eehc_pkg::EEHC_IDLE
      |-> ({8'h00, addr_q[`EEHC_COL_MSB:0]} + len_q) <= {7'h00, `EEHC_ROW_BYTES};
  endproperty
  a_row: assert property (p_row) else $error("page write crosses row");

  property p_wp_hold;
    @(posedge clk) disable iff (!rst_b)
      busy && $past(busy) |-> $stable(write_protect_input);
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("protect level moved mid command");
endmodule

// [sim/eehc_eeprom_model.sv]
// behavioural two-wire eeprom: select decode, addressing, page write, reads, polling
`timescale 1ns/10ps
`include "eehc_regs.svh"
module eehc_eeprom_model #(
  parameter logic [3:0] DEV  = `EEHC_DEV_TYPE,
  parameter int         PROG = 10000
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       wp,
  input  wire logic [2:0] strap,
  output logic            pull
);
  logic [7:0]  mem [4096];
  logic [7:0]  sh;
  logic [7:0]  pd[$];
  logic [11:0] ctr;
  logic [11:0] pa[$];
  logic        act = 0, rd = 0, ok = 0, wpl = 0;
  int          bitn = 0, nbyte = 0;
  realtime     free_at = 0;
  initial begin
    pull = 0;
    ctr = 12'h000;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // start: a busy array stays deaf until programming ends
  always @(negedge sda) if (scl) begin
    act = $realtime >= free_at;
    bitn = 0;
    nbyte = 0;
    wpl = wp;
    pa.delete();
    pd.delete();
  end
  always @(posedge sda) if (scl) begin
    // the stop slot's own scl rise has already been counted as one bit
    if (act && !rd && bitn == 1 && pa.size() > 0) begin
      foreach (pa[i]) mem[pa[i]] = pd[i];
      free_at = $realtime + PROG;
    end
    act = 0;
  end
  always @(posedge scl) if (act) begin
    if (bitn == 8) begin
      if (rd && nbyte > 1 && sda) act = 0;
      bitn = 0;
    end else begin
      sh = {sh[6:0], sda};
      wpl = wpl | (wp && nbyte < 3);
      if (bitn == 7) begin
        ok = 1;
        if (nbyte == 0) begin
          ok = sh[7:1] == {DEV, strap};
          rd = sh[0];
        end else if (rd) ctr = ctr + 12'h001;
        else if (nbyte == 1) ctr[11:8] = sh[3:0];
        else if (nbyte == 2) ctr[7:0] = sh;
        else begin
          ok = !wpl;
          if (ok) begin
            pa.push_back(ctr);
            pd.push_back(sh);
            ctr[4:0] = ctr[4:0] + 5'h01;
          end
        end
        nbyte++;
      end
      bitn++;
    end
  end
  always @(negedge scl) begin
    if (!act) pull = 0;
    else if (bitn == 8) pull = ok && !(rd && nbyte > 1);
    else pull = rd && nbyte > 0 && !mem[ctr][7 - bitn];
    if (bitn == 8 && !ok) act = 0;
  end
endmodule

// [sim/tb_eehc_master.sv]
// self-checking bench: eeprom host against a behavioural eeprom
`timescale 1ns/10ps
module tb_eehc_master;
  logic                clk = 0, rst_b = 0, cmd_valid = 0, wr_valid = 0, protect_en = 0;
  eehc_pkg::eehc_cmd_e cmd_op = eehc_pkg::EEHC_CMD_WRITE;
  logic [11:0]         cmd_addr = 12'h000;
  logic [12:0]         cmd_len = 13'h0001;
  logic [2:0]          strap_sel = 3'h0, strap_pins;
  logic [7:0]          wr_data = 8'h00, rd_data;
  logic                cmd_ready, wr_ready, rd_valid, done, fail, busy, scl_o, sda_o;
  logic                sda_oe, wpi, pull;
  logic [31:0]         lfsr_q = 32'h28ef;
  logic [7:0]          shadow [4096];
  int                  fails = 0, n_checks = 0;
  // pulled-up wire: low while either party pulls
  wire                 sda = !(sda_oe || pull);
  always #2.5 clk = ~clk;
  eehc_master uut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .strap_sel(strap_sel),
    .protect_en(protect_en), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .fail(fail), .busy(busy),
    .scl_o(scl_o), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .write_protect_input(wpi), .select_strap_pins(strap_pins));
  eehc_eeprom_model dev (.scl(scl_o), .sda(sda), .wp(wpi), .strap(strap_pins), .pull(pull));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // offers one command, feeds write bytes, checks read bytes against the shadow copy
  task automatic run(input eehc_pkg::eehc_cmd_e op, input logic [11:0] a,
                     input logic [12:0] n, input logic prot, input logic fail_exp);
    logic [11:0] ra;
    int          k;
    ra = a;
    lfsr_q = lfsr_next(lfsr_q);
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    protect_en = prot;
    strap_sel = lfsr_q[2:0];
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("busy", busy, 8'h01);
    for (k = 0; k < 40000 && done !== 1'b1; k++) begin
      if (wr_ready === 1'b1 && !wr_valid) begin
        lfsr_q = lfsr_next(lfsr_q);
        wr_data = lfsr_q[7:0];
        wr_valid = 1'b1;
        if (!prot) shadow[ra] = wr_data;
        ra = ra + 12'h001;
      end else wr_valid = 1'b0;
      if (rd_valid === 1'b1) begin
        chk("rd_data", rd_data, shadow[ra]);
        ra = ra + 12'h001;
      end
      @(negedge clk);
    end
    chk("done", done, 8'h01);
    chk("cmd_ready", cmd_ready, 8'h01);
    chk("sda_o", sda_o, 8'h00);
    chk("fail", fail, fail_exp);
    chk("protect pin", wpi, prot);
    chk("strap pins", strap_pins, strap_sel);
    @(negedge clk);
  endtask
  initial begin
    foreach (shadow[i]) shadow[i] = 8'hff;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    run(eehc_pkg::EEHC_CMD_WRITE, 12'h000, 13'h0001, 1'b1, 1'b1);
    run(eehc_pkg::EEHC_CMD_READ_CUR, 12'h000, 13'h0001, 1'b0, 1'b0);
    run(eehc_pkg::EEHC_CMD_WRITE, 12'h01e, 13'h0002, 1'b0, 1'b0);
    run(eehc_pkg::EEHC_CMD_READ_RND, 12'h01e, 13'h0002, 1'b0, 1'b0);
    summarize();
  end
  // the four commands need about 435 us including one poll round
  initial begin
    #450us;
    fails++;
    summarize();
  end
endmodule
